// *** pssc_cap_model.sv ***
`timescale 1ns/1ps
// Ramp capacitor stand-in; stalls stretch the ramp so that no fixed ramp length can be relied on.
module pssc_cap_model import pssc_pkg::*; #(parameter int DLY = 6) (
  input wire logic clock_i,
  input wire logic stall_i,
  input pssc_pkg::pssc_ramp_cmd_t ramp_cmd_i,
  output pssc_pkg::pssc_ramp_sense_t ramp_sense_o
);
  int lvl_ff[4];
  // Charge toward bias, discharge toward ground.
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!stall_i && ramp_cmd_i.ramp_up[i] && lvl_ff[i] < DLY) begin
        lvl_ff[i] <= lvl_ff[i] + 1;
      end else if (!stall_i && ramp_cmd_i.ramp_down[i] && lvl_ff[i] > 0) begin
        lvl_ff[i] <= lvl_ff[i] - 1;
      end
    end
  end
  // Level indications are steady while the level holds.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ramp_sense_o.bias_reached[i] = lvl_ff[i] == DLY;
      ramp_sense_o.ground_reached[i] = lvl_ff[i] == 0;
    end
  end
endmodule : pssc_cap_model

// *** pssc_pkg.sv ***
package pssc_pkg;

  // Channel sequencing states, Gray coded along reset release, ramp, wait and run.
  typedef enum logic [2:0] {
    PSSC_OFF       = 3'b000,
    PSSC_RAMP_UP   = 3'b001,
    PSSC_WAIT_EDGE = 3'b011,
    PSSC_ACTIVE    = 3'b010,
    PSSC_FAULT     = 3'b110,
    PSSC_RAMP_DOWN = 3'b100
  } pssc_state_t;

  // Output mode select encodings that change inversion or ramp coverage.
  localparam logic [2:0] PSSC_MODE_HALF_MONO = 3'h1;
  localparam logic [2:0] PSSC_MODE_STEREO_INV = 3'h4;
  localparam logic [2:0] PSSC_MODE_HALF_MONO_INV = 3'h5;
  localparam logic [2:0] PSSC_MODE_PARALLEL_INV = 3'h6;

  // Per-output inversion masks, bit n is power output n+1.
  localparam logic [3:0] PSSC_INV_NONE = 4'h0;
  localparam logic [3:0] PSSC_INV_STEREO = 4'ha;
  localparam logic [3:0] PSSC_INV_HALF_MONO = 4'h8;
  localparam logic [3:0] PSSC_INV_PARALLEL = 4'hc;

  // Ramp coverage masks.
  localparam logic [3:0] PSSC_RAMP_ALL = 4'hf;
  localparam logic [3:0] PSSC_RAMP_HALF_ONLY = 4'h3;

  // Register map, byte addresses.
  localparam logic [3:0] PSSC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] PSSC_ADDR_STATUS = 4'h4;

  // Control register fields and reset value.
  localparam int PSSC_CTRL_RAMP_ALLOW_BIT = 0;
  localparam logic [31:0] PSSC_CTRL_RESET = 32'h0000_0001;

  // Status register layout: four 3-bit states, then four edge-seen bits.
  localparam int PSSC_STAT_STATE_LSB = 0;
  localparam int PSSC_STAT_EDGE_LSB = 12;

  // Analog ramp circuit indications per output.
  typedef struct packed {
    logic [3:0] bias_reached;
    logic [3:0] ground_reached;
  } pssc_ramp_sense_t;

  // Commands to the analog ramp circuit per output.
  typedef struct packed {
    logic [3:0] ramp_up;
    logic [3:0] ramp_down;
  } pssc_ramp_cmd_t;

  // Power output drive: level and enable, enable low is high impedance.
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] drive_en;
  } pssc_power_t;

  // Classic Wishbone request.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } pssc_wb_req_t;

  // Classic Wishbone answer.
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pssc_wb_rsp_t;

endpackage : pssc_pkg

// *** pssc_top.sv ***
// Behaviour
// R1 - Pair reset low: pair in low power, internal state cleared.
// R2 - Pair reset low: that pair's power outputs at high impedance.
// R3 - Pair reset high: outputs follow ramp enable, mode select, PWM inputs.
// R4 - Ramping enabled: reset release ramps outputs up to half supply.
// R5 - No switching on a ramping output before bias is reached.
// R6 - Ramping enabled: reset assertion ramps outputs down to power ground.
// R7 - Modes 001 and 101 ramp only outputs 1 and 2.
// R8 - New ramp up or down accepted any time, even mid-ramp.
// R9 - After release, output stays high impedance until its input edge.
// R10 - Edge wait tracked per input/output pair independently.
// R11 - Only a rising input edge activates its output.
// R12 - Active output keeps switching until error or pair reset low.
// R13 - Ramp-up of outputs 1-2 and 3-4 follows their own pair reset.
// R14 - Edge during ramp-up: finish ramp, then switch immediately.
// R15 - No edge by ramp end: high impedance until an edge arrives.
// R16 - Controller holds resets low until supply stable, then starts PWM.
// R17 - Controller mutes inputs at 50% duty before asserting resets.
// R18 - Controller asserts resets when supplies drop below operating levels.
// R19 - Controller keeps mode select static while either reset is high.
// R20 - Mode 100 inverts input 2 against 1 and input 4 against 3.
// R21 - Ramp end taken from bias-reached indication, not a cycle count.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module pssc_top (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic reset_pair_a_n_i,
  input wire logic reset_pair_b_n_i,
  input wire logic ramp_enable_i,
  input wire logic [2:0] output_mode_select_i,
  input wire logic [3:0] pwm_input_i,
  input wire logic [3:0] fault_i,
  input pssc_pkg::pssc_ramp_sense_t ramp_sense_i,
  output pssc_pkg::pssc_ramp_cmd_t ramp_cmd_o,
  output pssc_pkg::pssc_power_t power_output_o,
  input pssc_pkg::pssc_wb_req_t wb_req_i,
  output pssc_pkg::pssc_wb_rsp_t wb_rsp_o
);
  import pssc_pkg::*;

  logic [31:0] ctrl_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [3:0] pwm_prev_ff;
  logic [3:0] pair_run;
  logic [3:0] rise;
  logic [3:0] inv_mask;
  logic [3:0] ramp_mask;
  logic ramp_on;
  logic [3:0] level_ff;
  logic [3:0] drive_ff;
  logic [3:0] up_ff;
  logic [3:0] down_ff;
  logic [3:0] edge_seen_ff;
  logic [11:0] state_bits;
  logic [31:0] status_word;
  logic wb_hit;

  // Outputs 1-2 follow the first pair reset, outputs 3-4 the second.
  // R13 pair reset routing
  assign pair_run = {reset_pair_b_n_i, reset_pair_b_n_i, reset_pair_a_n_i, reset_pair_a_n_i};

  // Software may veto ramping, for boards whose high supply is too high for it.
  assign ramp_on = ramp_enable_i & ctrl_ff[PSSC_CTRL_RAMP_ALLOW_BIT];

  // Input history for edge detection; inputs are synchronous to the clock.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pwm_prev_ff <= 4'h0;
    end else begin
      pwm_prev_ff <= pwm_input_i;
    end
  end

  // R11 rising edge only
  assign rise = pwm_input_i & ~pwm_prev_ff;

  // Mode decode for inversion; the reserved code behaves as plain pass-through.
  always_comb begin
    case (output_mode_select_i)
      // R20 internal inversion
      PSSC_MODE_STEREO_INV: inv_mask = PSSC_INV_STEREO;
      PSSC_MODE_HALF_MONO_INV: inv_mask = PSSC_INV_HALF_MONO;
      PSSC_MODE_PARALLEL_INV: inv_mask = PSSC_INV_PARALLEL;
      default: inv_mask = PSSC_INV_NONE;
    endcase
  end

  // The full-bridge pair never ramps in the 2.1 channel modes.
  always_comb begin
    // R7 ramp coverage
    if ((output_mode_select_i == PSSC_MODE_HALF_MONO) || (output_mode_select_i == PSSC_MODE_HALF_MONO_INV)) begin
      ramp_mask = PSSC_RAMP_HALF_ONLY;
    end else begin
      ramp_mask = PSSC_RAMP_ALL;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
      pssc_state_t state_ff;
      pssc_state_t nxt_state;
      logic can_ramp;

      assign can_ramp = ramp_on & ramp_mask[ch];

      // Sequencing for one output; every state has its own exit on pair reset.
      always_comb begin
        nxt_state = state_ff;
        case (state_ff)
          PSSC_OFF: begin
            if (pair_run[ch]) begin
              // R4 ramp on release
              nxt_state = can_ramp ? PSSC_RAMP_UP : PSSC_WAIT_EDGE;
            end
          end
          PSSC_RAMP_UP: begin
            if (!pair_run[ch]) begin
              // R8 reverse mid-ramp
              nxt_state = PSSC_RAMP_DOWN;
            end else if (ramp_sense_i.bias_reached[ch]) begin
              // R21 bias indication ends ramp
              // R14 pending edge starts switching
              // R15 otherwise wait
              nxt_state = (edge_seen_ff[ch] | rise[ch]) ? PSSC_ACTIVE : PSSC_WAIT_EDGE;
            end
          end
          PSSC_WAIT_EDGE: begin
            if (!pair_run[ch]) begin
              nxt_state = can_ramp ? PSSC_RAMP_DOWN : PSSC_OFF;
            end else if (rise[ch]) begin
              // R10 per-output activation
              nxt_state = PSSC_ACTIVE;
            end
          end
          PSSC_ACTIVE: begin
            if (!pair_run[ch]) begin
              nxt_state = can_ramp ? PSSC_RAMP_DOWN : PSSC_OFF;
            end else if (fault_i[ch]) begin
              // R12 stop on error
              nxt_state = PSSC_FAULT;
            end
          end
          PSSC_FAULT: begin
            if (!pair_run[ch]) begin
              nxt_state = can_ramp ? PSSC_RAMP_DOWN : PSSC_OFF;
            end
          end
          PSSC_RAMP_DOWN: begin
            if (pair_run[ch]) begin
              // R8 restart ramp-up
              nxt_state = PSSC_RAMP_UP;
            end else if (ramp_sense_i.ground_reached[ch]) begin
              // R6 ramp down ends at ground
              nxt_state = PSSC_OFF;
            end
          end
          default: nxt_state = PSSC_OFF;
        endcase
      end

      // R1 state cleared under pair reset
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          state_ff <= PSSC_OFF;
        end else begin
          state_ff <= nxt_state;
        end
      end

      // An edge during ramp-up is remembered so switching starts at ramp end.
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          edge_seen_ff[ch] <= 1'b0;
        end else if (!pair_run[ch]) begin
          // R1 clear internal state
          edge_seen_ff[ch] <= 1'b0;
        end else if ((state_ff == PSSC_RAMP_UP) && rise[ch]) begin
          edge_seen_ff[ch] <= 1'b1;
        end else if (state_ff != PSSC_RAMP_UP) begin
          edge_seen_ff[ch] <= 1'b0;
        end
      end

      // Power drive is enabled only in the next state that switches.
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          drive_ff[ch] <= 1'b0;
          level_ff[ch] <= 1'b0;
        end else begin
          // R2 high impedance in reset
          // R5 no switching while ramping
          // R9 high impedance until edge
          drive_ff[ch] <= (nxt_state == PSSC_ACTIVE);
          // R3 follow the input per mode
          level_ff[ch] <= (nxt_state == PSSC_ACTIVE) & (pwm_input_i[ch] ^ inv_mask[ch]);
        end
      end

      // Commands to the analog ramp circuit.
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          up_ff[ch] <= 1'b0;
          down_ff[ch] <= 1'b0;
        end else begin
          up_ff[ch] <= (nxt_state == PSSC_RAMP_UP);
          down_ff[ch] <= (nxt_state == PSSC_RAMP_DOWN);
        end
      end

      assign state_bits[3*ch +: 3] = state_ff;
    end
  endgenerate

  assign power_output_o.level = level_ff;
  assign power_output_o.drive_en = drive_ff;
  assign ramp_cmd_o.ramp_up = up_ff;
  assign ramp_cmd_o.ramp_down = down_ff;

  // Status word shows each channel's state and its remembered edge.
  assign status_word = {16'h0000, edge_seen_ff, state_bits};

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.
  assign wb_hit = wb_req_i.cyc & wb_req_i.stb;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_hit & ~ack_ff;
    end
  end

  // Read data is captured as ack rises, so it stands while ack is high.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (wb_hit & ~ack_ff & ~wb_req_i.we) begin
      case (wb_req_i.adr)
        PSSC_ADDR_CTRL: rdat_ff <= ctrl_ff;
        PSSC_ADDR_STATUS: rdat_ff <= status_word;
        default: rdat_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Writes land at the edge where the master samples ack; only byte 0 is used.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_ff <= PSSC_CTRL_RESET;
    end else if (wb_hit & ack_ff & wb_req_i.we & wb_req_i.sel[0] && (wb_req_i.adr == PSSC_ADDR_CTRL)) begin
      ctrl_ff <= {31'h0000_0000, wb_req_i.dat[PSSC_CTRL_RAMP_ALLOW_BIT]};
    end
  end

  assign wb_rsp_o.ack = ack_ff;
  assign wb_rsp_o.dat = rdat_ff;

endmodule : pssc_top

// *** pssc_top_assertions.sv ***
`timescale 1ns/1ps
// Watches the pair sequencing at the top ports.
module pssc_checker import pssc_pkg::*; (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic reset_pair_a_n_i,
  input wire logic reset_pair_b_n_i,
  input wire logic ramp_enable_i,
  input wire logic [2:0] output_mode_select_i,
  input wire logic [3:0] pwm_input_i,
  input wire logic [3:0] fault_i,
  input pssc_pkg::pssc_ramp_sense_t ramp_sense_i,
  input pssc_pkg::pssc_ramp_cmd_t ramp_cmd_o,
  input pssc_pkg::pssc_power_t power_output_o
);
  // Short aliases keep the properties readable.
  wire logic [3:0] de = power_output_o.drive_en;
  wire logic [3:0] up = ramp_cmd_o.ramp_up;
  wire logic [2:0] md = output_mode_select_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_HIZ_A: assert property (!reset_pair_a_n_i |=> de[1:0] == 2'h0) else $error("pair a driven in reset");
  AST_NO_DRIVE: assert property ((up & de) == 4'h0) else $error("driven while ramping");
  AST_RAMP_START: assert property ($rose(reset_pair_a_n_i) && ramp_enable_i |=> up[1:0] == 2'h3)
    else $error("no ramp after release");
  AST_RAMP_HALF: assert property ($rose(reset_pair_b_n_i)
    && (md == PSSC_MODE_HALF_MONO || md == PSSC_MODE_HALF_MONO_INV) |=> up[3:2] == 2'h0)
    else $error("full bridge ramped");
  AST_RAMP_END: assert property (up[0] && ramp_sense_i.bias_reached[0] && reset_pair_a_n_i |=> !up[0])
    else $error("ramp kept after bias");
  AST_RAMP_DOWN: assert property ($fell(reset_pair_a_n_i) && ramp_enable_i && de[0] |=> ramp_cmd_o.ramp_down[0])
    else $error("no ramp down");
  AST_FAULT: assert property (fault_i[3] && reset_pair_b_n_i |=> !de[3]) else $error("driven in fault");
  AST_INV_2: assert property (de[1] && $past(md) == PSSC_MODE_STEREO_INV
    |-> power_output_o.level[1] == !$past(pwm_input_i[1])) else $error("output 2 not inverted");
endmodule : pssc_checker
bind pssc_top pssc_checker pssc_checker_i (.clock_i, .reset_i, .reset_pair_a_n_i, .reset_pair_b_n_i,
  .ramp_enable_i, .output_mode_select_i, .pwm_input_i, .fault_i, .ramp_sense_i, .ramp_cmd_o, .power_output_o);

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import pssc_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic reset_pair_a_n_i = 1'b0;
  logic reset_pair_b_n_i = 1'b0;
  logic ramp_enable_i = 1'b0;
  logic [2:0] output_mode_select_i = 3'h0;
  logic [3:0] pwm_input_i = 4'h0;
  logic [3:0] fault_i = 4'h0;
  pssc_wb_req_t wb_req_i = '0;
  pssc_ramp_sense_t ramp_sense_i;
  pssc_ramp_cmd_t ramp_cmd_o;
  pssc_power_t power_output_o;
  pssc_wb_rsp_t wb_rsp_o;
  logic [31:0] rd;
  logic [3:0] inv;
  logic [3:0] rmask;
  int error_cnt = 0;
  int checked = 0;
  int cyc_cnt = 0;
  pssc_top pssc_top_i (.clock_i, .reset_i, .reset_pair_a_n_i, .reset_pair_b_n_i, .ramp_enable_i,
    .output_mode_select_i, .pwm_input_i, .fault_i, .ramp_sense_i, .ramp_cmd_o, .power_output_o, .wb_req_i, .wb_rsp_o);
  // Odd modes stall the ramp every other cycle to model a slow capacitor.
  pssc_cap_model pssc_cap_model_i (.clock_i, .stall_i(output_mode_select_i[0] & cyc_cnt[0]),
    .ramp_cmd_i(ramp_cmd_o), .ramp_sense_o(ramp_sense_i));
  // Free-running clock.
  initial forever #5 clock_i = ~clock_i;
  // A hang ends the run as a failure.
  always @(posedge clock_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 4000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Classic single cycle; the request is held until the edge that samples ack.
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge clock_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
    do @(posedge clock_i); while (wb_rsp_o.ack !== 1'b1);
    rd = wb_rsp_o.dat;
    wb_req_i <= '0;
  endtask : wb
  task automatic step();
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : step
  initial begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    wb(1'b0, PSSC_ADDR_CTRL, '0);
    check("ctrl", rd, PSSC_CTRL_RESET);
    wb(1'b1, PSSC_ADDR_CTRL, '0);
    wb(1'b0, PSSC_ADDR_CTRL, '0);
    check("ctrl wr", rd, 32'h0);
    wb(1'b1, PSSC_ADDR_CTRL, PSSC_CTRL_RESET);
    wb(1'b0, 4'h8, '0);
    check("unmapped", rd, 32'h0);
    // Modes 0 to 6: release, first edge (during ramp in all but modes 3 and 6), all inputs, fault, power-down.
    for (int m = 0; m < 7; m++) begin
      inv = (m == 4) ? PSSC_INV_STEREO : (m == 5) ? PSSC_INV_HALF_MONO : (m == 6) ? PSSC_INV_PARALLEL : PSSC_INV_NONE;
      rmask = (m == 3 || m == 6) ? 4'h0 : (m == 1 || m == 5) ? PSSC_RAMP_HALF_ONLY : PSSC_RAMP_ALL;
      @(posedge clock_i);
      output_mode_select_i <= 3'(m); // mode changes only while both resets are low
      ramp_enable_i <= rmask != 4'h0;
      pwm_input_i <= 4'h8;
      @(posedge clock_i);
      reset_pair_a_n_i <= 1'b1;
      reset_pair_b_n_i <= 1'b1;
      step();
      check("ramp up", ramp_cmd_o.ramp_up, rmask);
      if (m == 2) begin
        @(posedge clock_i) reset_pair_a_n_i <= 1'b0;
        @(posedge clock_i) reset_pair_a_n_i <= 1'b1;
        // Only the first pair turns back; the second keeps ramping up.
        @(negedge clock_i);
        check("pair a only", ramp_cmd_o.ramp_down, 4'h3);
      end
      @(posedge clock_i) pwm_input_i <= 4'h1;
      step();
      while (ramp_cmd_o.ramp_up !== 4'h0) @(negedge clock_i);
      check("first edge", power_output_o.drive_en, 4'h1);
      @(posedge clock_i) pwm_input_i <= 4'hf;
      step();
      check("drive", power_output_o.drive_en, 4'hf);
      check("level hi", power_output_o.level, inv ^ 4'hf);
      @(posedge clock_i) pwm_input_i <= 4'h0;
      step();
      check("level lo", power_output_o.level, inv);
      @(posedge clock_i) fault_i <= 4'h8;
      @(posedge clock_i) fault_i <= 4'h0;
      step();
      check("fault", power_output_o.drive_en, 4'h7);
      wb(1'b0, PSSC_ADDR_STATUS, '0);
      check("status", rd & 32'hfff, 32'hc92);
      repeat (4) @(posedge clock_i) pwm_input_i <= ~pwm_input_i;
      @(posedge clock_i);
      reset_pair_a_n_i <= 1'b0;
      reset_pair_b_n_i <= 1'b0;
      step();
      check("hi-z", power_output_o.drive_en, 4'h0);
      check("ramp down", ramp_cmd_o.ramp_down, rmask);
      while (ramp_cmd_o.ramp_down !== 4'h0) @(negedge clock_i);
    end
    end_sim();
  end
endmodule : tb
